// file: shared/qdr_pkg.sv
// How it works
// [RULE1] high-speed master code is never acknowledged
// [RULE2] write-addressed byte is acknowledged on match
// [RULE3] control byte is acknowledged and latched
// [RULE4] read-addressed byte acknowledged, then device transmits
// [RULE5] flag clear: high then low byte
// [RULE6] flag set: power-down byte, high, low
// [RULE7] channel-select bits choose the readback channel
// [RULE8] control byte field layout decode
// [RULE9] master acks all but last byte
// [RULE10] power-up clears every channel to zero
// [RULE11] select bits map to three power-down loads
// [RULE12] flag clear means normal data, active output
// [RULE13] power-down keeps stored output code
// [RULE14] staging and output registers ten bits wide
// [RULE15] high byte top bits go to bits nine, eight
// [RULE16] power-down uses same load and update path
// [RULE17] power-down write takes exactly two bytes
// [RULE18] device never drives the serial clock
// [RULE19] address matches fixed prefix plus pins
`default_nettype none
package qdr_pkg;
	// ----------------------------------------
	// link protocol
	// ----------------------------------------
	localparam logic [4:0] QDR_ADDR_PREFIX = 5'h13;
	localparam logic [7:0] QDR_HS_CODE = 8'h08;
	localparam logic [5:0] QDR_PD_FILL = 6'h3F;
	localparam logic [7:0] QDR_LOW_FILL = 8'h00;
	localparam int QDR_NCH = 4;
	localparam int QDR_REG_W = 10;
	localparam int QDR_CODE_W = 8;
	// control byte fields
	localparam int QDR_CTL_EXT_LO = 6;
	localparam int QDR_CTL_LOAD_LO = 4;
	localparam int QDR_CTL_SEL_LO = 1;
	localparam int QDR_CTL_PD = 0;
	// load modes
	localparam logic [1:0] QDR_LOAD_STORE = 2'h0;
	localparam logic [1:0] QDR_LOAD_ALL = 2'h2;
	// power-down select codes
	localparam logic [1:0] QDR_PWD_HIZ_A = 2'h0;
	localparam logic [1:0] QDR_PWD_1K = 2'h1;
	localparam logic [1:0] QDR_PWD_100K = 2'h2;
	localparam logic [1:0] QDR_PWD_HIZ_B = 2'h3;
	// ----------------------------------------
	// controller registers
	// ----------------------------------------
	localparam logic [7:0] QDR_REG_CTRL = 8'h00;
	localparam logic [7:0] QDR_REG_TXD = 8'h04;
	localparam logic [7:0] QDR_REG_STAT = 8'h08;
	localparam logic [7:0] QDR_REG_RXD = 8'h0C;
	localparam int QDR_CTRL_GO = 0;
	localparam int QDR_CTRL_HS = 1;
	localparam int QDR_CTRL_WR = 2;
	localparam logic [1:0] QDR_RESP_OKAY = 2'h0;
	localparam logic [1:0] QDR_RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int QDR_CLK_NS = 25;
	localparam int QDR_SCL_PERIOD_NS = 500;
	localparam int QDR_QTR_CYC = (QDR_SCL_PERIOD_NS / 4 + QDR_CLK_NS - 1) / QDR_CLK_NS;
endpackage : qdr_pkg
`default_nettype wire

// file: shared/qdr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qdr_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// open-drain wires with pull-ups
	assign scl = ~(m_scl_oe & ~m_scl_o);
	assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
	modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
		output m_sda_o, output m_sda_oe);
	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface : qdr_link_if
`default_nettype wire

// file: hdl/qdr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qdr_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset
	input wire logic [W-1:0] din, // asynchronous inputs
	output logic [W-1:0] q, // synchronised level
	output logic [W-1:0] q_prev // level one cycle older
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad
		$error("W below 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
			q_prev <= '0;
		end else begin
			meta_r <= din;
			q <= meta_r;
			q_prev <= q;
		end
	end
endmodule : qdr_sync
`default_nettype wire

// file: hdl/qdr_dac_end.sv
`timescale 1ns/1ps
`default_nettype none
module qdr_dac_end import qdr_pkg::*; (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset
	qdr_link_if.dev link, // two-wire link
	input wire logic addr_pin_zero, // address select pin
	input wire logic addr_pin_one, // address select pin
	input wire logic ext_addr_pin_low, // extended address pin
	input wire logic ext_addr_pin_high, // extended address pin
	output logic [QDR_NCH*QDR_CODE_W-1:0] dac_code, // output codes
	output logic [QDR_NCH*2-1:0] pwd_sel, // power-down select per channel
	output logic [QDR_NCH-1:0] out_hiz, // output open
	output logic [QDR_NCH-1:0] out_1k, // output 1k to ground
	output logic [QDR_NCH-1:0] out_100k, // output 100k to ground
	output logic [7:0] ctrl_byte // last control byte
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_RX = 3'b001,
		D_RXACK = 3'b011,
		D_TX = 3'b010,
		D_TXACK = 3'b110
	} qdr_dst_t;

	localparam logic [2:0] BIDX_ADDR = 3'h0;
	localparam logic [2:0] BIDX_CTRL = 3'h1;
	localparam logic [2:0] BIDX_HI = 3'h2;
	localparam logic [2:0] BIDX_LO = 3'h3;
	localparam logic [2:0] BIDX_DONE = 3'h4;

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [1:0] ln_q;
	logic [1:0] ln_p;
	logic [3:0] pin_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	qdr_sync #(.W(2)) u_link_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({link.scl, link.sda}),
		.q(ln_q),
		.q_prev(ln_p)
	);

	qdr_sync #(.W(4)) u_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din({ext_addr_pin_high, ext_addr_pin_low, addr_pin_one, addr_pin_zero}),
		.q(pin_q),
		.q_prev()
	);

	// edges and bus conditions
	assign scl_rise = ln_q[1] & ~ln_p[1];
	assign scl_fall = ~ln_q[1] & ln_p[1];
	assign bus_start = ln_q[1] & ln_p[1] & ln_p[0] & ~ln_q[0];
	assign bus_stop = ln_q[1] & ln_p[1] & ~ln_p[0] & ln_q[0];

	// ----------------------------------------
	// byte engine
	// ----------------------------------------
	qdr_dst_t st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [2:0] bidx_r;
	logic [1:0] tidx_r;
	logic rw_r;
	logic oe_r;
	logic [7:0] ctrl_r;
	logic ext_ok_r;
	logic rx_done;
	logic addr_hit;
	logic ack_now;
	logic [1:0] sel;
	logic pd_flag;
	logic [1:0] load_mode;
	logic wr_hi;
	logic wr_lo;
	logic [7:0] tx_cur;
	logic [QDR_REG_W-1:0] dac_vec [0:QDR_NCH-1];

	// reply byte at a position
	function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic pd,
		input logic [QDR_REG_W-1:0] r);
		logic [7:0] b;
		b = QDR_LOW_FILL;
		if (pd) begin
			if (idx == 2'h0) begin
				b = {r[9:8], QDR_PD_FILL}; // [RULE6]
			end else if (idx == 2'h1) begin
				b = r[7:0];
			end
		end else if (idx == 2'h0) begin
			b = r[7:0]; // [RULE5]
		end
		return b;
	endfunction : tx_byte

	// control byte fields
	assign sel = ctrl_r[QDR_CTL_SEL_LO +: 2]; // [RULE8]
	assign pd_flag = ctrl_r[QDR_CTL_PD];
	assign load_mode = ctrl_r[QDR_CTL_LOAD_LO +: 2];
	assign tx_cur = tx_byte(tidx_r, pd_flag, dac_vec[sel]); // [RULE7]

	// master code never matches
	assign addr_hit = sh_r[7:1] == {QDR_ADDR_PREFIX, pin_q[1:0]}; // [RULE19] [RULE1]
	assign rx_done = (st_r == D_RX) && scl_fall && (bit_r == 4'h8);
	assign ack_now = rx_done && ((bidx_r == BIDX_ADDR) ? addr_hit : (bidx_r != BIDX_DONE));
	assign wr_hi = ack_now && (bidx_r == BIDX_HI) && ext_ok_r;
	assign wr_lo = ack_now && (bidx_r == BIDX_LO) && ext_ok_r;

	// bit engine; scl is input only
	always_ff @(posedge clk_sys or posedge rst) begin // [RULE18]
		if (rst) begin
			st_r <= D_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			bidx_r <= BIDX_ADDR;
			tidx_r <= 2'h0;
			rw_r <= 1'b0;
			oe_r <= 1'b0;
		end else if (bus_start) begin
			st_r <= D_RX;
			bit_r <= 4'h0;
			bidx_r <= BIDX_ADDR;
			oe_r <= 1'b0;
		end else if (bus_stop) begin
			st_r <= D_IDLE;
			oe_r <= 1'b0;
		end else begin
			case (st_r)
				D_RX: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], ln_q[0]};
						bit_r <= bit_r + 4'h1;
					end else if (rx_done) begin
						if (ack_now) begin
							oe_r <= 1'b1; // [RULE2] [RULE3] [RULE4]
							st_r <= D_RXACK;
							if (bidx_r == BIDX_ADDR) begin
								rw_r <= sh_r[0];
								tidx_r <= 2'h0;
								bidx_r <= BIDX_CTRL;
							end else if (bidx_r == BIDX_LO) begin
								// power-down write takes two
								bidx_r <= pd_flag ? BIDX_DONE : BIDX_HI; // [RULE17]
							end else begin
								bidx_r <= bidx_r + 3'h1;
							end
						end else begin
							st_r <= D_IDLE; // foreign address or surplus byte
						end
					end
				end
				D_RXACK: begin
					if (scl_fall) begin
						bit_r <= 4'h0;
						if (rw_r) begin
							sh_r <= tx_cur; // [RULE4]
							oe_r <= ~tx_cur[7];
							st_r <= D_TX;
						end else begin
							oe_r <= 1'b0;
							st_r <= D_RX;
						end
					end
				end
				D_TX: begin
					if (scl_rise) begin
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_r == 4'h8) begin
							oe_r <= 1'b0;
							st_r <= D_TXACK;
						end else begin
							sh_r <= {sh_r[6:0], 1'b0};
							oe_r <= ~sh_r[6];
						end
					end
				end
				D_TXACK: begin
					// not-acknowledge ends the reply
					if (scl_rise) begin
						if (ln_q[0]) begin
							st_r <= D_IDLE; // [RULE9]
						end else if (tidx_r != 2'h3) begin
							tidx_r <= tidx_r + 2'h1;
						end
					end else if (scl_fall) begin
						sh_r <= tx_cur;
						oe_r <= ~tx_cur[7];
						bit_r <= 4'h0;
						st_r <= D_TX;
					end
				end
				default: begin
					st_r <= D_IDLE;
				end
			endcase
		end
	end

	// control byte latch
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_r <= 8'h00;
			ext_ok_r <= 1'b0;
		end else if (ack_now && (bidx_r == BIDX_CTRL)) begin
			ctrl_r <= sh_r; // [RULE3] [RULE8]
			ext_ok_r <= sh_r[QDR_CTL_EXT_LO +: 2] == pin_q[3:2];
		end
	end

	// open drain: value low, enable carries the bit
	assign link.d_sda_o = 1'b0;
	assign link.d_sda_oe = oe_r;
	assign ctrl_byte = ctrl_r;

	// ----------------------------------------
	// channel registers
	// ----------------------------------------
	for (genvar i = 0; i < QDR_NCH; i++) begin : g_ch
		logic [QDR_REG_W-1:0] stg_r; // staging_register
		logic [QDR_REG_W-1:0] dac_r; // dac_output_register
		logic stg_pd_r;
		logic dac_pd_r;
		logic upd;

		// store-only mode just stages
		assign upd = wr_lo && (load_mode != QDR_LOAD_STORE) &&
			((load_mode == QDR_LOAD_ALL) || (sel == 2'(i)));

		// power-on clears to code zero
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				stg_r <= '0; // [RULE10] [RULE14]
				dac_r <= '0;
				stg_pd_r <= 1'b0;
				dac_pd_r <= 1'b0;
			end else begin
				if (wr_hi && (sel == 2'(i))) begin
					if (pd_flag) begin
						stg_r[9:8] <= sh_r[7:6]; // [RULE15] [RULE13]
						stg_pd_r <= 1'b1;
					end else begin
						stg_r <= {2'b00, sh_r}; // [RULE12]
						stg_pd_r <= 1'b0;
					end
				end
				if (upd) begin
					dac_r <= stg_r; // [RULE16]
					dac_pd_r <= stg_pd_r;
				end
			end
		end

		// output load from held condition
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				out_hiz[i] <= 1'b0;
				out_1k[i] <= 1'b0;
				out_100k[i] <= 1'b0;
			end else begin
				out_hiz[i] <= dac_pd_r && ((dac_r[9:8] == QDR_PWD_HIZ_A) ||
					(dac_r[9:8] == QDR_PWD_HIZ_B)); // [RULE11]
				out_1k[i] <= dac_pd_r && (dac_r[9:8] == QDR_PWD_1K);
				out_100k[i] <= dac_pd_r && (dac_r[9:8] == QDR_PWD_100K);
			end
		end

		assign dac_vec[i] = dac_r;
		assign dac_code[i*QDR_CODE_W +: QDR_CODE_W] = dac_r[7:0];
		assign pwd_sel[i*2 +: 2] = dac_r[9:8];
	end
endmodule : qdr_dac_end
`default_nettype wire

// file: hdl/qdr_host_end.sv
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module qdr_host_end import qdr_pkg::*; #(
	parameter int QTR_CYC = QDR_QTR_CYC
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset
	qdr_link_if.host link, // two-wire link
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte lanes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // response valid
	input wire logic s_axi_bready, // response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready // read ready
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SEQ = 3'b001,
		H_START = 3'b011,
		H_BYTE = 3'b010,
		H_STOP = 3'b110
	} qdr_hst_t;
	typedef enum logic [1:0] {OP_START, OP_TX, OP_RX, OP_STOP} qdr_op_t;

	// a quarter must outlast sync
	if (QTR_CYC < 3 || QTR_CYC > 255) begin : g_bad
		$error("QTR_CYC out of range");
	end

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic aw_ok_r, w_ok_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_take, w_take, wr_do, ar_take, go;
	logic ctl_hs_r, ctl_wr_r, busy_r, nack_r;
	logic [7:0] ctl_byte_r;
	logic [9:0] txd_r;
	logic [23:0] rxd_r;

	// register index, 4 means unmapped
	function automatic logic [2:0] reg_idx(input logic [7:0] a);
		logic [2:0] r;
		if (a == QDR_REG_CTRL) r = 3'h0;
		else if (a == QDR_REG_TXD) r = 3'h1;
		else if (a == QDR_REG_STAT) r = 3'h2;
		else if (a == QDR_REG_RXD) r = 3'h3;
		else r = 3'h4;
		return r;
	endfunction : reg_idx

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_do = aw_ok_r & w_ok_r & ~s_axi_bvalid;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign go = wr_do && (reg_idx(awaddr_r) == 3'h0) && wstrb_r[0] &&
		wdata_r[QDR_CTRL_GO] && !busy_r;

	// aw and w in either order
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= QDR_RESP_OKAY;
		end else begin
			if (aw_take) awaddr_r <= s_axi_awaddr;
			if (w_take) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			aw_ok_r <= (aw_ok_r | aw_take) & ~wr_do;
			w_ok_r <= (w_ok_r | w_take) & ~wr_do;
			s_axi_awready <= ~((aw_ok_r | aw_take) & ~wr_do);
			s_axi_wready <= ~((w_ok_r | w_take) & ~wr_do);
			s_axi_bvalid <= (s_axi_bvalid & ~s_axi_bready) | wr_do;
			if (wr_do) begin
				s_axi_bresp <= (reg_idx(awaddr_r) == 3'h4) ? QDR_RESP_SLVERR : QDR_RESP_OKAY;
			end
		end
	end

	// read channel, one read in flight
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= QDR_RESP_OKAY;
		end else begin
			s_axi_rvalid <= (s_axi_rvalid & ~s_axi_rready) | ar_take;
			s_axi_arready <= ~((s_axi_rvalid & ~s_axi_rready) | ar_take);
			if (ar_take) begin
				s_axi_rresp <= QDR_RESP_OKAY;
				case (reg_idx(s_axi_araddr))
					3'h0: s_axi_rdata <= {16'h0, ctl_byte_r, 5'h0, ctl_wr_r, ctl_hs_r, 1'b0};
					3'h1: s_axi_rdata <= {22'h0, txd_r};
					3'h2: s_axi_rdata <= {30'h0, nack_r, busy_r};
					3'h3: s_axi_rdata <= {8'h0, rxd_r};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= QDR_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// settings frozen while busy
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctl_hs_r <= 1'b0;
			ctl_wr_r <= 1'b0;
			ctl_byte_r <= 8'h00;
			txd_r <= 10'h000;
		end else if (wr_do && !busy_r) begin
			if (reg_idx(awaddr_r) == 3'h0) begin
				if (wstrb_r[0]) {ctl_wr_r, ctl_hs_r} <= wdata_r[QDR_CTRL_WR:QDR_CTRL_HS];
				if (wstrb_r[1]) ctl_byte_r <= wdata_r[15:8];
			end else if (reg_idx(awaddr_r) == 3'h1) begin
				if (wstrb_r[0]) txd_r[7:0] <= wdata_r[7:0];
				if (wstrb_r[1]) txd_r[9:8] <= wdata_r[9:8];
			end
		end
	end

	// ----------------------------------------
	// link sequencer
	// ----------------------------------------
	qdr_hst_t st_r;
	logic [1:0] ph_r;
	logic [3:0] step_r, bit_r;
	logic [7:0] sh_r, cnt_r, obyte;
	logic scl_oe_r, sda_oe_r, ackl_r, ack_out, pd, tick, sda_s;
	qdr_op_t op;

	qdr_sync #(.W(1)) u_sda_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.din(link.sda),
		.q(sda_s),
		.q_prev()
	);

	assign pd = ctl_byte_r[QDR_CTL_PD];
	assign tick = cnt_r == 8'(QTR_CYC - 1);

	// step table; read acks all but last
	always_comb begin
		op = OP_STOP;
		obyte = 8'h00;
		ack_out = 1'b0;
		case (step_r)
			4'h0, 4'h2: op = OP_START;
			4'h1: begin op = OP_TX; obyte = QDR_HS_CODE; end // [RULE1]
			4'h3: begin op = OP_TX; obyte = {QDR_ADDR_PREFIX, txd_r[9:8], 1'b0}; end // [RULE2]
			4'h4: begin op = OP_TX; obyte = ctl_byte_r; end // [RULE3]
			4'h5: begin op = ctl_wr_r ? OP_TX : OP_START; obyte = txd_r[7:0]; end
			4'h6: begin
				op = OP_TX;
				obyte = ctl_wr_r ? QDR_LOW_FILL : {QDR_ADDR_PREFIX, txd_r[9:8], 1'b1}; // [RULE4]
			end
			4'h7: begin op = ctl_wr_r ? OP_STOP : OP_RX; ack_out = 1'b1; end
			4'h8: begin op = OP_RX; ack_out = pd; end // [RULE9]
			4'h9: op = pd ? OP_RX : OP_STOP;
			default: op = OP_STOP;
		endcase
	end

	// quarter-period divider
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) cnt_r <= 8'h00;
		else if (st_r == H_IDLE || st_r == H_SEQ || tick) cnt_r <= 8'h00;
		else cnt_r <= cnt_r + 8'h01;
	end

	// bit engine; never waits on scl
	always_ff @(posedge clk_sys or posedge rst) begin // [RULE18]
		if (rst) begin
			st_r <= H_IDLE;
			ph_r <= 2'h0;
			step_r <= 4'h0;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			busy_r <= 1'b0;
			nack_r <= 1'b0;
			ackl_r <= 1'b0;
			rxd_r <= 24'h0;
		end else begin
			case (st_r)
				H_IDLE: if (go) begin
					busy_r <= 1'b1;
					nack_r <= 1'b0;
					rxd_r <= 24'h0;
					step_r <= wdata_r[QDR_CTRL_HS] ? 4'h0 : 4'h2;
					st_r <= H_SEQ;
				end
				H_SEQ: begin
					ph_r <= 2'h0;
					bit_r <= 4'h0;
					sh_r <= obyte;
					st_r <= (op == OP_START) ? H_START : (op == OP_STOP) ? H_STOP : H_BYTE;
				end
				H_START: if (tick) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) sda_oe_r <= 1'b0;
					else if (ph_r == 2'h1) scl_oe_r <= 1'b0;
					else if (ph_r == 2'h2) sda_oe_r <= 1'b1;
					else begin
						scl_oe_r <= 1'b1;
						step_r <= step_r + 4'h1;
						st_r <= H_SEQ;
					end
				end
				H_BYTE: if (tick) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) begin
						sda_oe_r <= (bit_r == 4'h8) ? (op == OP_RX && ack_out) : (op == OP_TX && !sh_r[7]);
					end else if (ph_r == 2'h1) begin
						scl_oe_r <= 1'b0;
					end else if (ph_r == 2'h2) begin
						if (bit_r == 4'h8) ackl_r <= ~sda_s;
						else sh_r <= {sh_r[6:0], sda_s};
					end else begin
						scl_oe_r <= 1'b1;
						if (bit_r != 4'h8) begin
							bit_r <= bit_r + 4'h1;
						end else begin
							if (op == OP_RX) rxd_r <= {rxd_r[15:0], sh_r};
							// refusal aborts, bar master code
							if (op == OP_TX && !ackl_r && step_r != 4'h1) begin
								nack_r <= 1'b1;
								st_r <= H_STOP;
							end else begin
								step_r <= step_r + 4'h1;
								st_r <= H_SEQ;
							end
						end
					end
				end
				H_STOP: if (tick) begin
					ph_r <= ph_r + 2'h1;
					if (ph_r == 2'h0) sda_oe_r <= 1'b1;
					else if (ph_r == 2'h1) scl_oe_r <= 1'b0;
					else if (ph_r == 2'h2) sda_oe_r <= 1'b0;
					else begin
						busy_r <= 1'b0;
						st_r <= H_IDLE;
					end
				end
				default: st_r <= H_IDLE;
			endcase
		end
	end

	// open-drain drivers only ever pull low
	assign link.m_scl_o = 1'b0;
	assign link.m_sda_o = 1'b0;
	assign link.m_scl_oe = scl_oe_r;
	assign link.m_sda_oe = sda_oe_r;
endmodule : qdr_host_end
`default_nettype wire

// file: sim/qdr_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qdr_link_assertions (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset
	input wire logic scl, // resolved clock line
	input wire logic sda, // resolved data line
	input wire logic m_scl_oe, // host pulls clock low
	input wire logic m_sda_oe, // host pulls data low
	input wire logic d_sda_oe // device pulls data low
);
	logic [7:0] lo_cnt_r; // saturating
	// ----------------------------------------
	// helper
	// ----------------------------------------
	// clock-low age, for device timing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) lo_cnt_r <= 8'h00;
		else if (scl) lo_cnt_r <= 8'h00;
		else if (lo_cnt_r != 8'hFF) lo_cnt_r <= lo_cnt_r + 8'h01;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// start: data falls with clock held high
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	// stop: data rises with clock held high
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	property p_rel_after_rst;
		$past(rst) |-> !m_scl_oe && !m_sda_oe && !d_sda_oe;
	endproperty
	a_rel_after_rst: assert property (p_rel_after_rst)
		else $error("lines not released after reset");
	property p_scl_host;
		!scl |-> m_scl_oe;
	endproperty
	a_scl_host: assert property (p_scl_host)
		else $error("clock low without host");
	property p_scl_len;
		!scl |-> lo_cnt_r < 8'h28;
	endproperty
	a_scl_len: assert property (p_scl_len)
		else $error("clock held low too long");
	property p_dev_hold;
		scl && $past(scl) |-> $stable(d_sda_oe);
	endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("device moved data with clock high");
	property p_dev_move;
		$changed(d_sda_oe) |-> !scl && lo_cnt_r inside {[8'h02:8'h09]};
	endproperty
	a_dev_move: assert property (p_dev_move)
		else $error("device data change out of window");
	property p_start;
		s_start |-> m_sda_oe && !d_sda_oe;
	endproperty
	a_start: assert property (p_start)
		else $error("start not made by host");
	property p_stop;
		s_stop |-> !$past(d_sda_oe);
	endproperty
	a_stop: assert property (p_stop)
		else $error("device made a stop");
	property p_no_fight;
		scl && m_sda_oe |-> !d_sda_oe;
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("device drives during host bit");
endmodule : qdr_link_assertions
`default_nettype wire

// file: sim/quad_dac_hs_readback_powerdown_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_hs_readback_powerdown_tb_top import qdr_pkg::*;;
	logic clk_sys = 1'b0, rst = 1'b1; // clock, reset
	logic [1:0] ap = 2'h0; // device address pins
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, dac_code;
	logic [7:0] pwd_sel, ctrl_byte;
	logic [3:0] out_hiz, out_1k, out_100k;
	int mcode[4];
	int failures = 0, tests_run = 0;
	// ----------------------------------------
	// clock, link and ends
	// ----------------------------------------
	always #12.5 clk_sys = ~clk_sys;
	qdr_link_if link();
	qdr_dac_end u_qdr_dac_end(.clk_sys(clk_sys), .rst(rst), .link(link), .addr_pin_zero(ap[0]),
		.addr_pin_one(ap[1]), .ext_addr_pin_low(1'b0), .ext_addr_pin_high(1'b0),
		.dac_code(dac_code), .pwd_sel(pwd_sel), .out_hiz(out_hiz), .out_1k(out_1k),
		.out_100k(out_100k), .ctrl_byte(ctrl_byte));
	qdr_host_end #(.QTR_CYC(5)) u_qdr_host_end(.clk_sys(clk_sys), .rst(rst), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	qdr_link_assertions u_chk(.clk_sys(clk_sys), .rst(rst), .scl(link.scl), .sda(link.sda),
		.m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe), .d_sda_oe(link.d_sda_oe));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d, failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic stall;
		failures++;
		$display("CHECK FAILED wait exp done got timeout");
		conclude();
	endtask : stall
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// write: address and data together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		r = bresp;
		bready <= 1'b0;
		if (n >= 100) stall();
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 100) stall();
	endtask : axr
	// one link sequence, polled until idle
	task automatic op(input logic [1:0] pins, input logic [7:0] cb, input logic hs,
		input logic wr, input logic [7:0] hb, output logic [31:0] rx, output logic nk);
		logic [1:0] r;
		logic [31:0] s;
		int n = 0;
		axw(QDR_REG_TXD, {22'h0, pins, hb}, r);
		axw(QDR_REG_CTRL, {16'h0, cb, 5'h0, wr, hs, 1'b1}, r);
		do begin
			axr(QDR_REG_STAT, s, r);
			n++;
		end while (s[0] !== 1'b0 && n < 2000);
		if (n >= 2000) stall();
		axr(QDR_REG_RXD, rx, r);
		nk = s[1];
	endtask : op
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] rx;
		logic [1:0] r, ms;
		logic nk;
		int c;
		c = $urandom(32'hD5803C9B);
		ap <= c[1:0];
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("codes", 32'h0, dac_code);
		chk("pwd", 32'h0, {24'h0, pwd_sel});
		for (int ch = 0; ch < 4; ch++) begin
			mcode[ch] = $urandom % 256;
			op(ap, {4'h1, 1'b0, ch[1:0], 1'b0}, c[ch + 4], 1'b1, mcode[ch][7:0], rx, nk);
			chk("ack", 32'h0, {31'h0, nk});
			chk("ctrl", {4'h1, 1'b0, ch[1:0], 1'b0}, {24'h0, ctrl_byte});
			chk("code", mcode[ch], {24'h0, dac_code[ch*8+:8]});
		end
		// reverse order exposes a stale select
		for (int ch = 3; ch >= 0; ch--) begin
			op(ap, {4'h1, 1'b0, ch[1:0], 1'b0}, 1'b1, 1'b0, 8'h00, rx, nk);
			chk("read2", {mcode[ch][7:0], 8'h00}, rx[15:0]);
			chk("rdack", 32'h0, {31'h0, nk});
		end
		$display("test normal data done");
		for (int ch = 0; ch < 4; ch++) begin
			ms = ch[1:0] ^ 2'h1;
			op(ap, {4'h1, 1'b0, ch[1:0], 1'b1}, 1'b1, 1'b1, {ms, 6'h00}, rx, nk);
			chk("hsack", 32'h0, {31'h0, nk});
			chk("pwd", ms, pwd_sel[ch*2+:2]);
			chk("load", {ms == 2'h0 || ms == 2'h3, ms == 2'h1, ms == 2'h2},
				{out_hiz[ch], out_1k[ch], out_100k[ch]});
			chk("kept", mcode[ch], {24'h0, dac_code[ch*8+:8]});
			op(ap, {4'h1, 1'b0, ch[1:0], 1'b1}, 1'b1, 1'b0, 8'h00, rx, nk);
			chk("read3", {ms, 6'h3F, mcode[ch][7:0], 8'h00}, rx[23:0]);
		end
		$display("test power down done");
		mcode[0] = $urandom % 256;
		op(ap, 8'h10, 1'b0, 1'b1, mcode[0][7:0], rx, nk);
		chk("active", {mcode[0][7:0], 5'h0},
			{dac_code[7:0], pwd_sel[1:0], out_hiz[0], out_1k[0], out_100k[0]});
		mcode[1] = $urandom % 256;
		op(ap, 8'h22, 1'b0, 1'b1, mcode[1][7:0], rx, nk);
		chk("all", {mcode[3][7:0], mcode[2][7:0], mcode[1][7:0], mcode[0][7:0]},
			dac_code);
		op(~ap, 8'h10, 1'b0, 1'b1, 8'hA5, rx, nk);
		chk("nack", 32'h1, {31'h0, nk});
		chk("ignored", mcode[0], {24'h0, dac_code[7:0]});
		axw(8'h10, 32'h1, r);
		chk("bresp", QDR_RESP_SLVERR, r);
		$display("test address and access done");
		conclude();
	end
endmodule : quad_dac_hs_readback_powerdown_tb_top
`default_nettype wire
